// File: design/tcu_regs.svh
/*
 Register offsets, field positions, reset values and prescaler match values of the
 capture unit. Assumes an AXI4-Lite slave with 32-bit data, one word per register.
*/
// What this block does
// - On each qualified event copy the 16-bit time base into the capture pair.
// - Mode selects falling, rising, every 4th or every 16th rising edge.
// - Every capture sets the capture event flag.
// - A new capture overwrites an unread value without protection.
// - With the pin as output, a latch write changing the level may capture.
// - A mode change may set the flag spuriously.
// - Prescaler counter held clear when off or not in capture mode.
// - Every reset clears the prescaler counter.
// - Changing between capture prescales does not clear the counter.
// - In sleep with instruction clock the timer holds, then resumes.
// - With external clock, capture keeps working during sleep.
// - Capture logic identical in all four unit instances.
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH

`define TCU_OFF_CONTROL    8'h00
`define TCU_OFF_VALUE_LOW  8'h04
`define TCU_OFF_VALUE_HIGH 8'h08
`define TCU_OFF_FLAG       8'h0C
`define TCU_OFF_ENABLE     8'h10
`define TCU_OFF_PIN        8'h14
`define TCU_OFF_TIMEBASE   8'h18

`define TCU_CONTROL_RESET  8'h00
`define TCU_MODE_LSB       0
`define TCU_MODE_MSB       3

`define TCU_PIN_DIR_BIT    0
`define TCU_PIN_LATCH_BIT  1
`define TCU_PIN_LEVEL_BIT  2

`define TCU_TB_RUN_BIT     0
`define TCU_TB_EXT_BIT     1

`define TCU_PRESCALE_4     4'h3
`define TCU_PRESCALE_16    4'hF

`define TCU_RESP_OKAY      2'b00
`define TCU_RESP_SLVERR    2'b10

`endif

// File: design/tcu_pkg.sv
/*
 Types of the capture unit.
 Assumes tcu_regs.svh supplies the numeric constants.
*/
package tcu_pkg;
    // Capture mode codes of the unit mode select field
    typedef enum logic [3:0] {
        TCU_MODE_OFF     = 4'b0000,
        TCU_MODE_FALL    = 4'b0100,
        TCU_MODE_RISE    = 4'b0101,
        TCU_MODE_RISE4   = 4'b0110,
        TCU_MODE_RISE16  = 4'b0111
    } tcu_mode_t;
endpackage : tcu_pkg

// File: design/tcu_edge_qual.sv
/*
 Edge qualifier: synchronises the pin, detects edges and applies the
 edge prescaler. Assumes mclk domain and synchronous reset.
*/
`timescale 1ns/1ps
`include "tcu_regs.svh"
module tcu_edge_qual (
    input  wire logic       mclk,      // System clock
    input  wire logic       sys_rst,   // Synchronous reset
    input  wire logic       pin_level, // Effective pin level, async
    input  wire logic [3:0] mode,      // Unit mode select
    output logic            event_hit  // Qualified capture event pulse
);
    logic       sync_a;
    logic       sync_b;
    logic       level_d;
    logic [3:0] prescale;
    logic [3:0] next_prescale;
    logic       is_capture;
    logic       rise;
    logic       fall;
    logic       hit_rise4;
    logic       hit_rise16;
    logic       next_hit;

    // Capture modes occupy codes 0100..0111
    assign is_capture = (mode[3:2] == 2'b01);
    assign rise       = sync_b & ~level_d;
    assign fall       = ~sync_b & level_d;
    assign hit_rise4  = rise && ({2'b00, prescale[1:0]} == `TCU_PRESCALE_4);
    assign hit_rise16 = rise && (prescale == `TCU_PRESCALE_16);

    // Counter keeps running across prescale changes, so a switch may fire early
    always_comb begin
        next_hit      = 1'b0;
        next_prescale = prescale;
        if (!is_capture) begin
            next_prescale = 4'h0;
        end else begin
            case (mode)
                tcu_pkg::TCU_MODE_FALL:  next_hit = fall;
                tcu_pkg::TCU_MODE_RISE:  next_hit = rise;
                tcu_pkg::TCU_MODE_RISE4: next_hit = hit_rise4;
                tcu_pkg::TCU_MODE_RISE16: next_hit = hit_rise16;
                default:                 next_hit = 1'b0;
            endcase
            if (rise) begin
                next_prescale = prescale + 4'h1;
            end
        end
    end

    // Two-stage synchroniser; only sync_b feeds the edge logic
    always_ff @(posedge mclk) begin
        sync_a <= pin_level;
        sync_b <= sync_a;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            level_d   <= 1'b0;
            prescale  <= 4'h0;
            event_hit <= 1'b0;
        end else begin
            level_d   <= sync_b;
            prescale  <= next_prescale;
            event_hit <= next_hit;
        end
    end
endmodule : tcu_edge_qual

// File: design/tcu_capture_unit.sv
/*
 Input capture unit with its 16-bit time base and an AXI4-Lite register
 slave. Assumes a single mclk domain; the pin and the external time base
 tick are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "tcu_regs.svh"
module tcu_capture_unit (
    input  wire logic        mclk,          // System clock, 250 MHz
    input  wire logic        sys_rst,       // Synchronous reset, active high
    input  wire logic        sleep,         // Device asleep, level
    input  wire logic        ext_tick,      // External time base clock, async
    input  wire logic        pin_in,        // Capture pin level, async
    output logic             pin_out,       // Capture pin output level
    output logic             pin_oe,        // Capture pin output enable
    output logic             irq,           // Level interrupt
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready   // Read data ready
);
    logic [7:0]  unit_control;
    logic [7:0]  capture_value_low;
    logic [7:0]  capture_value_high;
    logic        capture_event_flag;
    logic        capture_event_irq_enable;
    logic        pin_direction_bit;   // 1 = input
    logic        pin_latch;
    logic        tb_run;
    logic        tb_ext;
    logic [15:0] timebase_count;
    logic        tick_a;
    logic        tick_b;
    logic        tick_d;
    logic        event_hit;
    logic        pin_level;
    logic        tb_step;
    logic        pin_a;
    logic        pin_b;

    // Write channel state
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_go;
    logic        wr_ok;
    logic [7:0]  wr_byte;
    logic        wr_lane0;
    logic        next_flag;
    logic        clr_flag;

    // Read path
    logic        rd_go;
    logic [31:0] rd_word;
    logic        rd_ok;

    // Pin as output drives the latch back into the detector
    assign pin_level = pin_direction_bit ? pin_b : pin_latch;

    // Same qualifier serves every unit instance, so capture never differs
    tcu_edge_qual u_edge_qual (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .pin_level (pin_level),
        .mode      (unit_control[`TCU_MODE_MSB:`TCU_MODE_LSB]),
        .event_hit (event_hit)
    );

    // Pin and external tick each cross by two flops before any logic reads them
    always_ff @(posedge mclk) begin
        tick_a <= ext_tick;
        tick_b <= tick_a;
        pin_a  <= pin_in;
        pin_b  <= pin_a;
    end

    // Instruction clock source stops in sleep; external source keeps counting
    assign tb_step = tb_run && (tb_ext ? (tick_b & ~tick_d) : ~sleep);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tick_d         <= 1'b0;
            timebase_count <= 16'h0000;
        end else begin
            tick_d <= tick_b;
            if (tb_step) begin
                timebase_count <= timebase_count + 16'h0001;
            end
        end
    end

    // Write decode: both channels held, then one write per response
    assign wr_go    = aw_held && w_held && !s_axi_bvalid;
    assign wr_byte  = w_data[7:0];
    assign wr_lane0 = w_strb[0];
    assign wr_ok    = (aw_addr == `TCU_OFF_CONTROL) || (aw_addr == `TCU_OFF_VALUE_LOW) ||
                      (aw_addr == `TCU_OFF_VALUE_HIGH) || (aw_addr == `TCU_OFF_FLAG) ||
                      (aw_addr == `TCU_OFF_ENABLE) || (aw_addr == `TCU_OFF_PIN) ||
                      (aw_addr == `TCU_OFF_TIMEBASE);
    assign clr_flag = wr_go && wr_lane0 && (aw_addr == `TCU_OFF_FLAG) && wr_byte[0];
    // Set wins over a clear in the same cycle; mode writes may set it falsely
    assign next_flag = event_hit | (capture_event_flag & ~clr_flag);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aw_held       <= 1'b0;
            aw_addr       <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TCU_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control and configuration registers, written through byte lane 0
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            unit_control             <= `TCU_CONTROL_RESET;
            capture_event_irq_enable <= 1'b0;
            pin_direction_bit        <= 1'b1;
            pin_latch                <= 1'b0;
            tb_run                   <= 1'b0;
            tb_ext                   <= 1'b0;
        end else if (wr_go && wr_lane0) begin
            if (aw_addr == `TCU_OFF_CONTROL) begin
                unit_control <= wr_byte;
            end
            if (aw_addr == `TCU_OFF_ENABLE) begin
                capture_event_irq_enable <= wr_byte[0];
            end
            if (aw_addr == `TCU_OFF_PIN) begin
                pin_direction_bit <= wr_byte[`TCU_PIN_DIR_BIT];
                pin_latch         <= wr_byte[`TCU_PIN_LATCH_BIT];
            end
            if (aw_addr == `TCU_OFF_TIMEBASE) begin
                tb_run <= wr_byte[`TCU_TB_RUN_BIT];
                tb_ext <= wr_byte[`TCU_TB_EXT_BIT];
            end
        end
    end

    // Capture pair: a hardware capture beats a software write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            capture_value_low  <= 8'h00;
            capture_value_high <= 8'h00;
        end else if (event_hit) begin
            capture_value_low  <= timebase_count[7:0];
            capture_value_high <= timebase_count[15:8];
        end else if (wr_go && wr_lane0) begin
            if (aw_addr == `TCU_OFF_VALUE_LOW) begin
                capture_value_low <= wr_byte;
            end
            if (aw_addr == `TCU_OFF_VALUE_HIGH) begin
                capture_value_high <= wr_byte;
            end
        end
    end

    // Sticky flag and interrupt output
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            capture_event_flag <= 1'b0;
            irq                <= 1'b0;
        end else begin
            capture_event_flag <= next_flag;
            irq                <= next_flag & capture_event_irq_enable;
        end
    end

    // Pin drive follows the direction bit and output latch
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= pin_latch;
            pin_oe  <= !pin_direction_bit;
        end
    end

    // Read decode
    assign rd_go = s_axi_arvalid && s_axi_arready;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `TCU_OFF_CONTROL:    rd_word = {24'h00_0000, unit_control};
            `TCU_OFF_VALUE_LOW:  rd_word = {24'h00_0000, capture_value_low};
            `TCU_OFF_VALUE_HIGH: rd_word = {24'h00_0000, capture_value_high};
            `TCU_OFF_FLAG:       rd_word = {31'h0000_0000, capture_event_flag};
            `TCU_OFF_ENABLE:     rd_word = {31'h0000_0000, capture_event_irq_enable};
            `TCU_OFF_PIN:        rd_word = {29'h0000_0000, pin_level, pin_latch,
                                            pin_direction_bit};
            `TCU_OFF_TIMEBASE:   rd_word = {timebase_count, 14'h0000, tb_ext, tb_run};
            default:             rd_ok   = 1'b0;
        endcase
    end

    // One read at a time; ready drops while the answer stands
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TCU_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? `TCU_RESP_OKAY : `TCU_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule : tcu_capture_unit

// File: verification/tcu_capture_props.sv
/*
 Port checker for the capture unit: bus handshakes, answers, reset.
 Assumes a bind from tb and the single mclk domain of the unit.
*/
`timescale 1ns/1ps
`include "tcu_regs.svh"
module tcu_capture_props (
    input wire logic        mclk,          // Clock
    input wire logic        sys_rst,       // Sync reset
    input wire logic        pin_oe,        // Pin enable
    input wire logic        irq,           // Interrupt
    input wire logic [7:0]  s_axi_awaddr,  // Write address
    input wire logic        s_axi_awvalid, // AW valid
    input wire logic        s_axi_awready, // AW ready
    input wire logic        s_axi_wvalid,  // W valid
    input wire logic        s_axi_wready,  // W ready
    input wire logic [1:0]  s_axi_bresp,   // B response
    input wire logic        s_axi_bvalid,  // B valid
    input wire logic        s_axi_bready,  // B ready
    input wire logic [7:0]  s_axi_araddr,  // Read address
    input wire logic        s_axi_arvalid, // AR valid
    input wire logic        s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata,   // R data
    input wire logic [1:0]  s_axi_rresp,   // R response
    input wire logic        s_axi_rvalid,  // R valid
    input wire logic        s_axi_rready   // R ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Both write channels taken on one edge
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Answers stand until the master takes them
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    // Unmapped places answer with an error and zero data
    wr_unmapped_a: assert property (wr_both ##0 (s_axi_awaddr > `TCU_OFF_TIMEBASE) |->
        ##2 s_axi_bresp == `TCU_RESP_SLVERR) else $error("unmapped write okay");
    rd_unmapped_a: assert property (rd_take ##0 (s_axi_araddr > `TCU_OFF_TIMEBASE) |=>
        s_axi_rresp == `TCU_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read okay");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[15:8] == 8'h00)
        else $error("byte register upper bits set");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid
        && !irq && !pin_oe) else $error("outputs busy after reset");
endmodule : tcu_capture_props

// File: verification/tcu_pin_model.sv
/*
 Far side model: drives the capture pin and the external time base clock.
 Assumes the bench calls its tasks; the pin has no pull.
*/
`timescale 1ns/1ps
module tcu_pin_model (
    input  wire logic pin_out,  // Unit drive level
    input  wire logic pin_oe,   // Unit drive enable
    output logic      pin_in,   // Resolved pin level
    output logic      ext_tick  // External time base clock
);
    logic drive; // Level of the outside source
    // Unit wins while driving; the unit feeds its own latch to the capture path then
    assign pin_in = pin_oe ? pin_out : drive;
    initial begin
        drive = 1'b0;
        ext_tick = 1'b0;
    end
    // Slow clock so the synchroniser sees every edge; still between ticks
    task automatic tick();
        ext_tick <= 1'b1;
        #20;
        ext_tick <= 1'b0;
        #20;
    endtask : tick
    task automatic level(input logic v);
        drive <= v;
    endtask : level
endmodule : tcu_pin_model

// File: verification/tb.sv
/*
 Self-checking bench of the capture unit over AXI4-Lite.
 Assumes external time base ticks counted one each, so captures are exact.
*/
`timescale 1ns/1ps
`include "tcu_regs.svh"
module tb;
    logic        mclk, sys_rst, sleep, pin_in, ext_tick, pin_out, pin_oe, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, c1;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [15:0] base;
    logic [3:0]  modes [4];
    int          pres [4];
    int          err_total, checks_done;

    tcu_capture_unit u_dut (.mclk(mclk), .sys_rst(sys_rst), .sleep(sleep),
        .ext_tick(ext_tick), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    tcu_pin_model u_pin (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_tick(ext_tick));

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Both write channels offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, d, exp);
    endtask : rdchk

    // Pin high then low, each level long enough for sync and capture
    task automatic pulse();
        u_pin.level(1'b1);
        repeat (10) @(posedge mclk);
        u_pin.level(1'b0);
        repeat (10) @(posedge mclk);
    endtask : pulse

    // Irq off, unit off if off is set, new mode, stale flag cleared, count noted
    task automatic set_mode(input logic [3:0] m, input bit off);
        wr(`TCU_OFF_ENABLE, 32'h0000_0000);
        if (off) wr(`TCU_OFF_CONTROL, 32'h0000_0000);
        wr(`TCU_OFF_CONTROL, {28'h000_0000, m});
        wr(`TCU_OFF_FLAG, 32'h0000_0001);
        rd(`TCU_OFF_TIMEBASE);
        base = d[31:16];
    endtask : set_mode

    task automatic test_done();
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Hang guard, about eight times the expected run of some 1200 cycles
    initial begin
        #40000;
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        {sys_rst, sleep, awvalid, wvalid, bready, arvalid, rready} = 7'b100_0000;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'h1};
        modes = '{tcu_pkg::TCU_MODE_FALL, tcu_pkg::TCU_MODE_RISE,
                  tcu_pkg::TCU_MODE_RISE4, tcu_pkg::TCU_MODE_RISE16};
        pres = '{1, 1, 4, 16};
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rdchk("control_reset", `TCU_OFF_CONTROL, 32'h0000_0000);
        rdchk("pin_reset", `TCU_OFF_PIN, 32'h0000_0001);
        rd(8'h40);
        chk("unmapped_rd", {r, d[29:0]}, {`TCU_RESP_SLVERR, 30'h0000_0000});
        wr(8'h40, 32'h0000_00FF);
        chk("unmapped_wr", r, `TCU_RESP_SLVERR);
        wr(`TCU_OFF_TIMEBASE, 32'h0000_0003);
        // Every mode; off in between so no edge carries over
        for (int m = 0; m < 4; m++) begin
            set_mode(modes[m], 1'b1);
            for (int i = 0; i < pres[m]; i++) begin
                if (i == pres[m] - 1) rdchk("early_flag", `TCU_OFF_FLAG, 0);
                u_pin.tick();
                pulse();
            end
            base = base + pres[m][15:0];
            rdchk("flag_set", `TCU_OFF_FLAG, 32'h0000_0001);
            rdchk("value_low", `TCU_OFF_VALUE_LOW, {24'h00_0000, base[7:0]});
            rdchk("value_high", `TCU_OFF_VALUE_HIGH, {24'h00_0000, base[15:8]});
        end
        repeat (40) @(posedge mclk);
        rdchk("flag_sticky", `TCU_OFF_FLAG, 32'h0000_0001);
        wr(`TCU_OFF_ENABLE, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        chk("irq_on", irq, 1'b1);
        wr(`TCU_OFF_FLAG, 32'h0000_0001);
        repeat (3) @(posedge mclk);
        chk("irq_off", irq, 1'b0);
        // Two unread captures while asleep on the external clock
        set_mode(tcu_pkg::TCU_MODE_RISE, 1'b1);
        wr(`TCU_OFF_ENABLE, 32'h0000_0001);
        sleep <= 1'b1;
        u_pin.tick();
        pulse();
        u_pin.tick();
        u_pin.tick();
        pulse();
        sleep <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("irq_sleep", irq, 1'b1);
        rdchk("overwrite", `TCU_OFF_VALUE_LOW, {24'h00_0000, base[7:0] + 8'h03});
        // Direct prescale change keeps the two edges already counted
        set_mode(tcu_pkg::TCU_MODE_RISE4, 1'b0);
        pulse();
        rdchk("keep_count_a", `TCU_OFF_FLAG, 32'h0000_0000);
        pulse();
        rdchk("keep_count_b", `TCU_OFF_FLAG, 32'h0000_0001);
        // Latch write with the pin as output makes an edge
        set_mode(tcu_pkg::TCU_MODE_RISE, 1'b1);
        wr(`TCU_OFF_PIN, 32'h0000_0000);
        wr(`TCU_OFF_FLAG, 32'h0000_0001);
        wr(`TCU_OFF_PIN, 32'h0000_0002);
        repeat (8) @(posedge mclk);
        chk("pin_drive", {pin_oe, pin_out}, 2'b11);
        rdchk("latch_capture", `TCU_OFF_FLAG, 32'h0000_0001);
        // Internal time base halts in sleep and resumes after
        wr(`TCU_OFF_TIMEBASE, 32'h0000_0001);
        sleep <= 1'b1;
        rd(`TCU_OFF_TIMEBASE);
        c1 = d;
        repeat (20) @(posedge mclk);
        rd(`TCU_OFF_TIMEBASE);
        chk("sleep_hold", d[31:16], c1[31:16]);
        sleep <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(`TCU_OFF_TIMEBASE);
        chk("sleep_resume", d[31:16] > c1[31:16], 1);
        test_done();
    end
endmodule : tb

bind tcu_capture_unit tcu_capture_props u_props (.mclk(mclk), .sys_rst(sys_rst),
    .pin_oe(pin_oe), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
